/* hw/operand_addr_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module operand_addr_unit
	import opsel_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Configuration
	input wire logic i_cfg_wr,
	input wire logic i_short_register_flag,
	// Operand request
	input wire op_req_type i_req,
	input wire logic [23:0] i_pc,
	input wire logic [31:0] i_mem_rdata,
	// Register file write port
	input wire logic i_rf_wr,
	input wire logic [3:0] i_rf_idx,
	input wire logic [15:0] i_rf_data,
	// Stack and processor register control
	input wire logic i_stk_valid,
	input wire stack_op_type i_stk_op,
	input wire logic i_load_proc_reg_double_instr_valid,
	input wire logic [15:0] i_load_proc_reg_double_instr_data,
	// Results
	output op_resp_type o_resp,
	output logic [23:0] o_stack_addr,
	output logic o_stack_isp,
	output logic o_user_mode,
	output logic [15:0] o_processor_status_register,
	output logic o_short_register_flag
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0] regs [NUM_REGS];
	logic short_register_flag;
	logic [15:0] processor_status_register;
	op_resp_type resp_reg, resp_next;
	logic [23:0] stack_addr_raw;
	logic stack_isp_raw;
	logic user_raw;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] pair_value(input logic [3:0] idx, input logic sr);
		logic [3:0] hi;
		hi = idx + 4'h1;
		// specials are 32-bit pairs unless flag set
		if (idx >= FIRST_BASE_IDX && sr)
			pair_value = {16'h0000, regs[idx]};
		else
			pair_value = {regs[hi], regs[idx]};
	endfunction : pair_value

	function automatic logic [23:0] zext(input logic [23:0] v, input int w);
		zext = v & ((24'h000001 << w) - 24'h000001);
	endfunction : zext

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire [31:0] base_pair = pair_value(i_req.base_sel ? SECOND_BASE_IDX : FIRST_BASE_IDX,
		short_register_flag);
	wire [31:0] ra_pair = pair_value(i_req.reg_a, short_register_flag);
	wire [23:0] ra_word = {8'h00, regs[i_req.reg_a]};
	wire [23:0] base_addr = base_pair[23:0];
	wire [23:0] pair_addr = ra_pair[23:0];
	wire [23:0] d14 = zext(i_req.field, DISP14_W);
	wire [23:0] d20 = zext(i_req.field, DISP20_W);
	wire [15:0] dst_old = regs[i_req.reg_a];
	wire [15:0] byte_merge = {dst_old[15:8], i_req.src_data[7:0]};

	// Response formation
	always_comb begin
		resp_next = '0;
		resp_next.valid = i_req.valid;
		resp_next.wr_idx = i_req.reg_a;
		case (i_req.mode)
			MODE_REG: begin
				resp_next.operand = i_req.dbl_op ? ra_pair : {16'h0000, dst_old};
				resp_next.wr_en = i_req.valid;
				resp_next.wr_lo = i_req.byte_op ? byte_merge : i_req.src_data;
				resp_next.wr_hi = dst_old;
			end
			MODE_IMM: resp_next.operand = {8'h00, i_req.field};
			MODE_REL_PC, MODE_BRANCH: resp_next.addr = i_pc + i_req.field;
			MODE_REL_REG: begin
				resp_next.is_mem = 1'b1;
				resp_next.addr = ra_word + i_req.field;
			end
			MODE_REL_PAIR: begin
				resp_next.is_mem = 1'b1;
				resp_next.addr = pair_addr + i_req.field;
			end
			MODE_IDX_REL14: begin
				resp_next.is_mem = 1'b1;
				resp_next.bad_idx = short_register_flag;
				resp_next.addr = base_addr + pair_addr + d14;
			end
			MODE_IDX_REL20: begin
				resp_next.is_mem = 1'b1;
				resp_next.bad_idx = short_register_flag;
				resp_next.addr = base_addr + pair_addr + d20;
			end
			MODE_IDX_ABS: begin
				resp_next.is_mem = 1'b1;
				resp_next.bad_idx = short_register_flag;
				resp_next.addr = base_addr + d20;
			end
			MODE_ABS20: begin
				resp_next.is_mem = 1'b1;
				resp_next.addr = d20;
			end
			MODE_ABS24: begin
				resp_next.is_mem = 1'b1;
				resp_next.addr = i_req.field;
			end
			default: ;
		endcase
		// double load splits into the pair
		if (i_req.dbl_op && i_req.mode != MODE_REG && i_req.mode != MODE_IMM) begin
			resp_next.wr_en = i_req.valid;
			resp_next.wr_pair = 1'b1;
			resp_next.wr_lo = i_mem_rdata[15:0];
			resp_next.wr_hi = i_mem_rdata[31:16];
		end else if (i_req.dbl_op && i_req.mode == MODE_REG) begin
			resp_next.wr_pair = 1'b1;
			resp_next.wr_hi = ra_pair[31:16];
		end
	end

	// Stack pointer selection
	stack_ptr_select u_stack (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_op_valid(i_stk_valid),
		.i_op(i_stk_op),
		.o_stack_addr(stack_addr_raw),
		.o_user_mode(user_raw),
		.o_uses_isp(stack_isp_raw)
	);

	// Register file writes
	always_ff @(posedge i_clk) begin
		if (i_ce && i_rf_wr) regs[i_rf_idx] <= i_rf_data;
		if (i_ce && resp_next.wr_en) begin
			regs[i_req.reg_a] <= resp_next.wr_lo;
			if (resp_next.wr_pair) regs[i_req.reg_a + 4'h1] <= resp_next.wr_hi;
		end
	end

	// Configuration, status and outputs
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			short_register_flag <= 1'b0;
			processor_status_register <= PSR_RESET;
			resp_reg <= '0;
			o_stack_addr <= SP_RESET;
			o_stack_isp <= 1'b0;
		end else if (i_ce) begin
			if (i_cfg_wr) short_register_flag <= i_short_register_flag;
			if (i_load_proc_reg_double_instr_valid && !user_raw) processor_status_register <= i_load_proc_reg_double_instr_data;
			resp_reg <= resp_next;
			o_stack_addr <= stack_addr_raw;
			o_stack_isp <= stack_isp_raw;
		end
	end

	assign o_resp = resp_reg;
	assign o_user_mode = user_raw;
	assign o_processor_status_register = {processor_status_register[15:8], user_raw,
		processor_status_register[6:0]};
	assign o_short_register_flag = short_register_flag;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_branch;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_req.valid && i_req.mode == MODE_BRANCH) |=> o_resp.addr == $past(i_pc) + $past(i_req.field);
	endproperty
	a_branch: assert property (p_branch) else $error("branch target wrong");
	property p_imm;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_req.valid && i_req.mode == MODE_IMM) |=> !o_resp.is_mem;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate touched memory");
	property p_abs24;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_req.mode == MODE_ABS24) |=> o_resp.addr == $past(i_req.field);
	endproperty
	a_abs24: assert property (p_abs24) else $error("absolute address wrong");
	property p_idx_bad;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_req.mode == MODE_IDX_ABS) |=> o_resp.bad_idx == $past(short_register_flag);
	endproperty
	a_idx_bad: assert property (p_idx_bad) else $error("index flag check wrong");
	property p_reset_sr;
		@(posedge i_clk) !i_rst_n |=> !o_short_register_flag;
	endproperty
	a_reset_sr: assert property (p_reset_sr) else $error("flag not cleared");
	property p_load_proc_reg_double_instr;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_load_proc_reg_double_instr_valid && user_raw) |=> $stable(processor_status_register);
	endproperty
	a_load_proc_reg_double_instr: assert property (p_load_proc_reg_double_instr) else $error("status changed in user mode");
	property p_exc;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_stk_valid && i_stk_op == STK_EXC_ENTRY) |=> !o_user_mode && o_stack_isp;
	endproperty
	a_exc: assert property (p_exc) else $error("exception entry wrong");
	property p_user_entry;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_user_mode) |-> $past(i_stk_op == STK_JUMP_TO_USER_INSTR || i_stk_op == STK_EXC_RETURN);
	endproperty
	a_user_entry: assert property (p_user_entry) else $error("bad user entry");
	property p_push;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_stk_valid && i_stk_op == STK_PUSH) |-> stack_addr_raw == u_stack.prog_sp - PUSH_STEP;
	endproperty
	a_push: assert property (p_push) else $error("push not downward");
	c_branch: cover property (@(posedge i_clk) i_req.valid && i_req.mode == MODE_BRANCH);
	c_exc: cover property (@(posedge i_clk) i_stk_valid && i_stk_op == STK_EXC_ENTRY);
	c_jump_to_user_instr: cover property (@(posedge i_clk) $rose(o_user_mode));
endmodule : operand_addr_unit
`default_nettype wire

/* hw/opsel_pkg.sv */
package opsel_pkg;
	// ------------------------------------------------------------
	// Widths and field layout
	// ------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 24;
	localparam int NUM_REGS = 16;
	localparam int REG_IDX_W = 4;
	localparam int DISP14_W = 14;
	localparam int DISP20_W = 20;
	localparam int ABS20_W = 20;
	localparam int ABS24_W = 24;
	localparam int BYTE_W = 8;
	// Register indices of the pair-capable specials
	localparam logic [3:0] FIRST_BASE_IDX = 4'hC;
	localparam logic [3:0] SECOND_BASE_IDX = 4'hD;
	localparam logic [3:0] RET_ADDR_IDX = 4'hE;
	localparam logic [3:0] STACK_IDX = 4'hF;
	// Processor status bit positions
	localparam int PSR_U_BIT = 7;
	// Reset values and stack step sizes
	localparam logic [23:0] SP_RESET = 24'h000000;
	localparam logic [15:0] PSR_RESET = 16'h0000;
	localparam logic [23:0] PUSH_STEP = 24'h000002;
	localparam logic [23:0] FRAME_STEP = 24'h000004;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_REG, MODE_IMM, MODE_REL_PC, MODE_REL_REG, MODE_REL_PAIR,
		MODE_IDX_REL14, MODE_IDX_REL20, MODE_IDX_ABS, MODE_ABS20, MODE_ABS24,
		MODE_BRANCH
	} addr_mode_type;

	typedef enum logic [2:0] {
		STK_NONE, STK_PUSH, STK_POP, STK_POP_AND_RETURN_INSTR, STK_EXC_ENTRY, STK_EXC_RETURN,
		STK_JUMP_TO_USER_INSTR
	} stack_op_type;

	typedef struct packed {
		logic valid;
		addr_mode_type mode;
		logic byte_op;
		logic dbl_op;
		logic base_sel;
		logic [3:0] reg_a;
		logic [23:0] field;
		logic [15:0] src_data;
	} op_req_type;

	typedef struct packed {
		logic valid;
		logic is_mem;
		logic [23:0] addr;
		logic [31:0] operand;
		logic wr_en;
		logic [3:0] wr_idx;
		logic [15:0] wr_lo;
		logic [15:0] wr_hi;
		logic wr_pair;
		logic bad_idx;
	} op_resp_type;
endpackage : opsel_pkg

/* hw/stack_ptr_select.sv */
`timescale 1ns/100ps
`default_nettype none
module stack_ptr_select
	import opsel_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Stack request
	input wire logic i_op_valid,
	input wire stack_op_type i_op,
	// Current pointers and mode
	output logic [23:0] o_stack_addr,
	output logic o_user_mode,
	output logic o_uses_isp
);
	logic [23:0] supervisor_stack_pointer_reg, supervisor_stack_pointer_next;
	logic [23:0] user_stack_pointer_reg, user_stack_pointer_next;
	logic [23:0] interrupt_stack_pointer_reg, interrupt_stack_pointer_next;
	logic user_reg, user_next;
	logic saved_user_reg, saved_user_next;
	logic [23:0] prog_sp;
	wire go = i_ce && i_op_valid;

	assign prog_sp = user_reg ? user_stack_pointer_reg : supervisor_stack_pointer_reg;

	// Pointer and mode updates
	always_comb begin
		supervisor_stack_pointer_next = supervisor_stack_pointer_reg;
		user_stack_pointer_next = user_stack_pointer_reg;
		interrupt_stack_pointer_next = interrupt_stack_pointer_reg;
		user_next = user_reg;
		saved_user_next = saved_user_reg;
		o_stack_addr = prog_sp;
		o_uses_isp = 1'b0;
		if (go) begin
			case (i_op)
				STK_PUSH: begin
					o_stack_addr = prog_sp - PUSH_STEP;
					if (user_reg) user_stack_pointer_next = prog_sp - PUSH_STEP;
					else supervisor_stack_pointer_next = prog_sp - PUSH_STEP;
				end
				STK_POP, STK_POP_AND_RETURN_INSTR: begin
					if (user_reg) user_stack_pointer_next = prog_sp + PUSH_STEP;
					else supervisor_stack_pointer_next = prog_sp + PUSH_STEP;
				end
				STK_EXC_ENTRY: begin
					o_uses_isp = 1'b1;
					o_stack_addr = interrupt_stack_pointer_reg - FRAME_STEP;
					interrupt_stack_pointer_next = interrupt_stack_pointer_reg - FRAME_STEP;
					saved_user_next = user_reg;
					user_next = 1'b0;
				end
				STK_EXC_RETURN: begin
					o_uses_isp = 1'b1;
					o_stack_addr = interrupt_stack_pointer_reg;
					interrupt_stack_pointer_next = interrupt_stack_pointer_reg + FRAME_STEP;
					user_next = saved_user_reg;
				end
				STK_JUMP_TO_USER_INSTR: user_next = 1'b1;
				default: ;
			endcase
		end
	end

	// State registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			supervisor_stack_pointer_reg <= SP_RESET;
			user_stack_pointer_reg <= SP_RESET;
			interrupt_stack_pointer_reg <= SP_RESET;
			user_reg <= 1'b0;
			saved_user_reg <= 1'b0;
		end else if (i_ce) begin
			supervisor_stack_pointer_reg <= supervisor_stack_pointer_next;
			user_stack_pointer_reg <= user_stack_pointer_next;
			interrupt_stack_pointer_reg <= interrupt_stack_pointer_next;
			user_reg <= user_next;
			saved_user_reg <= saved_user_next;
		end
	end
	assign o_user_mode = user_reg;
endmodule : stack_ptr_select
`default_nettype wire

/* dv/opsel_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Operand memory seen by the address unit
// ------------------------------------------------------------
module opsel_mem
	import opsel_pkg::*;
(
	// Operand address in
	input wire logic [23:0] i_addr,
	// Double-word read data out
	output logic [31:0] o_rdata
);
	// Content depends on every address bit, so a wrong address shows
	always_comb begin
		o_rdata = {i_addr[15:0] ^ 16'h5A3C, i_addr[23:8]};
	end
endmodule : opsel_mem
`default_nettype wire

/* dv/cpu_operand_address_and_stack_select_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_operand_address_and_stack_select_bench;
	import opsel_pkg::*;
	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	logic i_clk, i_rst_n, i_cfg_wr, i_flag, i_rf_wr, i_stk_valid, i_load_proc_reg_double_instr_valid;
	op_req_type i_req;
	logic [23:0] i_pc, mem_addr, o_stack_addr, sp_m, usp_m, isp_m, ea;
	logic [31:0] mem_rdata;
	logic [3:0] i_rf_idx;
	logic [15:0] i_rf_data, i_load_proc_reg_double_instr_data, o_psr, psr_m, d;
	stack_op_type i_stk_op;
	op_resp_type o_resp;
	logic o_stack_isp, o_user_mode, o_flag, user_m, saved_u, eisp;
	logic [15:0] rf [16];
	int miscompares, checks_done;
	op_req_type r;
	addr_mode_type mlist [9] = '{MODE_REL_PC, MODE_REL_REG, MODE_REL_PAIR, MODE_IDX_REL14,
		MODE_IDX_REL20, MODE_IDX_ABS, MODE_ABS20, MODE_ABS24, MODE_BRANCH};
	stack_op_type slist [12] = '{STK_PUSH, STK_PUSH, STK_POP, STK_POP_AND_RETURN_INSTR, STK_EXC_ENTRY,
		STK_EXC_RETURN, STK_JUMP_TO_USER_INSTR, STK_PUSH, STK_EXC_ENTRY, STK_PUSH, STK_EXC_RETURN, STK_POP};

	operand_addr_unit dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cfg_wr(i_cfg_wr),
		.i_short_register_flag(i_flag), .i_req(i_req), .i_pc(i_pc), .i_mem_rdata(mem_rdata),
		.i_rf_wr(i_rf_wr), .i_rf_idx(i_rf_idx), .i_rf_data(i_rf_data), .i_stk_valid(i_stk_valid),
		.i_stk_op(i_stk_op), .i_load_proc_reg_double_instr_valid(i_load_proc_reg_double_instr_valid), .i_load_proc_reg_double_instr_data(i_load_proc_reg_double_instr_data),
		.o_resp(o_resp), .o_stack_addr(o_stack_addr), .o_stack_isp(o_stack_isp),
		.o_user_mode(o_user_mode), .o_processor_status_register(o_psr),
		.o_short_register_flag(o_flag));
	opsel_mem mem_u (.i_addr(mem_addr), .o_rdata(mem_rdata));

	// Clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// Tasks and reference model
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	function automatic logic [31:0] pair(input logic [3:0] a);
		return {rf[a + 4'h1], rf[a]};
	endfunction : pair

	function automatic logic [23:0] exp_addr(input op_req_type q);
		logic [23:0] b;
		b = pair(q.base_sel ? SECOND_BASE_IDX : FIRST_BASE_IDX);
		case (q.mode)
			MODE_REL_PC, MODE_BRANCH: return i_pc + q.field;
			MODE_REL_REG: return {8'h00, rf[q.reg_a]} + q.field;
			MODE_REL_PAIR: return pair(q.reg_a) + q.field;
			MODE_IDX_REL14: return b + pair(q.reg_a) + {10'h000, q.field[13:0]};
			MODE_IDX_REL20: return b + pair(q.reg_a) + {4'h0, q.field[19:0]};
			MODE_IDX_ABS: return b + {4'h0, q.field[19:0]};
			MODE_ABS20: return {4'h0, q.field[19:0]};
			default: return q.field;
		endcase
	endfunction : exp_addr

	function automatic op_req_type mk(input addr_mode_type m, input logic [3:0] a);
		op_req_type q;
		q = '0;
		q.valid = 1'b1;
		q.mode = m;
		q.reg_a = a;
		q.base_sel = $urandom_range(0, 1);
		q.field = $urandom;
		q.src_data = $urandom;
		return q;
	endfunction : mk

	task automatic issue(input op_req_type q);
		@(posedge i_clk);
		i_req <= q;
		mem_addr <= exp_addr(q);
		@(posedge i_clk);
		i_req.valid <= 1'b0;
		#1;
	endtask : issue

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge i_clk);
		i_rf_wr <= 1'b1;
		i_rf_idx <= a;
		i_rf_data <= v;
		@(posedge i_clk);
		i_rf_wr <= 1'b0;
		rf[a] = v;
	endtask : wr_reg

	task automatic stk(input stack_op_type op);
		@(posedge i_clk);
		i_stk_valid <= 1'b1;
		i_stk_op <= op;
		@(posedge i_clk);
		i_stk_valid <= 1'b0;
		#1;
		eisp = 1'b0;
		case (op)
			STK_PUSH: begin
				if (user_m) usp_m -= PUSH_STEP; else sp_m -= PUSH_STEP;
				ea = user_m ? usp_m : sp_m;
			end
			STK_POP, STK_POP_AND_RETURN_INSTR: begin
				ea = user_m ? usp_m : sp_m;
				if (user_m) usp_m += PUSH_STEP; else sp_m += PUSH_STEP;
			end
			STK_EXC_ENTRY: begin
				saved_u = user_m;
				user_m = 1'b0;
				isp_m -= FRAME_STEP;
				ea = isp_m;
				eisp = 1'b1;
			end
			STK_EXC_RETURN: begin
				ea = isp_m;
				isp_m += FRAME_STEP;
				user_m = saved_u;
				eisp = 1'b1;
			end
			default: user_m = 1'b1;
		endcase
		if (op != STK_JUMP_TO_USER_INSTR) chk(o_stack_addr, ea, "stack addr");
		if (op != STK_JUMP_TO_USER_INSTR) chk(o_stack_isp, eisp, "isp use");
		chk(o_user_mode, user_m, "user mode");
	endtask : stk

	task automatic load_proc_reg_double_instr(input logic [15:0] v);
		@(posedge i_clk);
		i_load_proc_reg_double_instr_valid <= 1'b1;
		i_load_proc_reg_double_instr_data <= v;
		@(posedge i_clk);
		i_load_proc_reg_double_instr_valid <= 1'b0;
		#1;
		if (!user_m) psr_m = v;
		psr_m[PSR_U_BIT] = user_m;
		chk(o_psr, psr_m, "status reg");
	endtask : load_proc_reg_double_instr

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [3:0] a;
		{i_rst_n, i_cfg_wr, i_flag, i_rf_wr, i_stk_valid, i_load_proc_reg_double_instr_valid} = '0;
		i_req = '0;
		i_pc = 24'h001000;
		mem_addr = '0;
		i_rf_idx = '0;
		i_rf_data = '0;
		i_load_proc_reg_double_instr_data = '0;
		i_stk_op = STK_NONE;
		{sp_m, usp_m, isp_m, user_m, saved_u, psr_m} = '0;
		miscompares = 0;
		checks_done = 0;
		void'($urandom(32'hD9466FC1));
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		chk(o_flag, 1'b0, "flag reset");
		chk(o_psr, PSR_RESET, "status reset");
		for (int i = 0; i < 16; i++) wr_reg(i[3:0], $urandom);
		$display("test registers done");
		// Every address mode except register and immediate, with random fields; base register not written back
		// flag kept clear while index modes run
		for (int k = 0; k < 27; k++) begin
			a = $urandom_range(0, 10);
			i_pc <= $urandom;
			r = mk(mlist[k % 9], a);
			issue(r);
			chk(o_resp.addr, exp_addr(r), "operand address");
		end
		$display("test address modes done");
		// Immediate and byte register operands
		for (int k = 0; k < 4; k++) begin
			a = $urandom_range(0, 10);
			r = mk(MODE_IMM, a);
			issue(r);
			chk(o_resp.operand, {8'h00, r.field}, "immediate value");
			chk(o_resp.is_mem, 1'b0, "immediate no memory");
			r = mk(MODE_REG, a);
			r.byte_op = 1'b1;
			d = {rf[a][15:8], r.src_data[7:0]};
			issue(r);
			chk(o_resp.operand, {16'h0000, rf[a]}, "register operand");
			chk(o_resp.wr_lo, d, "byte keeps high");
			rf[a] = d;
		end
		$display("test immediate and byte done");
		// Stack pointers, exceptions and user mode
		for (int k = 0; k < 12; k++) stk(slist[k]);
		load_proc_reg_double_instr($urandom);
		stk(STK_EXC_ENTRY);
		load_proc_reg_double_instr($urandom);
		$display("test stacks done");
		// Short-register flag set: specials become single registers
		@(posedge i_clk);
		i_cfg_wr <= 1'b1;
		i_flag <= 1'b1;
		@(posedge i_clk);
		i_cfg_wr <= 1'b0;
		#1;
		chk(o_flag, 1'b1, "flag set");
		r = mk(MODE_IDX_ABS, 4'h0);
		issue(r);
		chk(o_resp.bad_idx, 1'b1, "index with flag set");
		ea = {8'h00, rf[r.base_sel ? SECOND_BASE_IDX : FIRST_BASE_IDX]} + {4'h0, r.field[19:0]};
		chk(o_resp.addr, ea, "single base register");
		$display("test short flag done");
		complete_run();
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		complete_run();
	end
endmodule : cpu_operand_address_and_stack_select_bench
`default_nettype wire
